// >>> logic/rmps_regs.svh
// Purpose: Constants for the radio mode packet sequencer
// Assumes: 20 MHz system clock
// Notes: Included by the core only
`ifndef RMPS_REGS_SVH
`define RMPS_REGS_SVH
`define RMPS_CLK_MHZ 20
`define RMPS_SETTLE_US 650
`define RMPS_BIT_KBPS 50
`define RMPS_PRE_BITS 9'h00a
`define RMPS_CRC_W 16
`define RMPS_CRC_POLY 16'h1021
`define RMPS_CRC_INIT 16'hffff
`define RMPS_OP_W_TXPAY 8'h20
`define RMPS_OP_W_TXADR 8'h22
`define RMPS_OP_R_RXPAY 8'h24
`define RMPS_ST_DONE 7
`define RMPS_ST_HIT 5
`define RMPS_AFW_RST 3'h4
`define RMPS_PW_RST 6'h20
`define RMPS_ADR_RST 32'h00000000
`define RMPS_PAY_BYTES 32
`define RMPS_ADR_BYTES 4
`endif

// >>> logic/rmps_pkg.sv
// Purpose: Types of the radio mode packet sequencer
// Assumes: Nothing
// Notes: Shared by core and bench
`default_nettype none
package rmps_pkg;
  typedef enum logic [2:0] {M_OFF, M_STBY, M_RXS, M_RX, M_TX, M_DRAIN} rmps_mode_t;
  typedef enum logic [3:0] {
    B_IDLE, B_PRE, B_ADR, B_PAY, B_CRC, B_CW, B_HUNT, B_RPAY, B_RCRC
  } rmps_bst_t;
  typedef struct packed {
    logic pwr;
    logic ce;
    logic txen;
    logic sck;
    logic csn;
    logic mosi;
    logic car;
  } rmps_pins_t;
  typedef struct packed {
    logic rep;
    logic [2:0] tx_afw;
    logic [2:0] rx_afw;
    logic [5:0] tx_pw;
    logic [5:0] rx_pw;
    logic [31:0] rx_adr;
  } rmps_cfg_t;
  typedef struct packed {
    logic ack;
    logic busy;
    logic dt;
    logic ot;
    logic ht;
  } rmps_xing_t;
endpackage : rmps_pkg
`default_nettype wire

// >>> logic/rmps_core.sv
// Purpose: Mode control, SPI slave and burst packet framer
// Assumes: Bit clock from the modem; SCK well below I_CLK/4
// Notes: Config and buffers cross domains quasi-statically
`timescale 1ns/100ps
`default_nettype none
`include "rmps_regs.svh"
module rmps_core import rmps_pkg::*; #(
  parameter int SETTLE_CYC = `RMPS_SETTLE_US * `RMPS_CLK_MHZ,
  parameter int CRC_W = `RMPS_CRC_W,
  parameter logic [CRC_W-1:0] CRC_POLY = `RMPS_CRC_POLY,
  parameter logic [CRC_W-1:0] CRC_INIT = `RMPS_CRC_INIT,
  parameter int PAY_BYTES = `RMPS_PAY_BYTES
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_BIT_CLK,
  input wire logic I_CHIP_POWER_REQUEST,
  input wire logic I_RADIO_ENABLE_INPUT,
  input wire logic I_TRANSMIT_SELECT,
  input wire logic I_SCK,
  input wire logic I_CSN,
  input wire logic I_MOSI,
  input wire logic I_REPEAT_SEND_BIT,
  input wire logic [2:0] I_TX_AFW,
  input wire logic [2:0] I_RX_AFW,
  input wire logic [5:0] I_TX_PW,
  input wire logic [5:0] I_RX_PW,
  input wire logic [31:0] I_RX_ADDR,
  input wire logic I_RF_CARRIER,
  input wire logic I_RF_RX_DATA,
  output logic O_MISO,
  output logic O_PACKET_DONE_FLAG,
  output logic O_ADDRESS_HIT_FLAG,
  output logic O_CARRIER_SENSE_FLAG,
  output logic O_OSC_ON,
  output logic O_RADIO_POWER,
  output logic O_RX_LISTEN,
  output logic O_TX_CARRIER,
  output logic O_TX_MODULATE,
  output logic O_TX_DATA
);
  localparam int SC_W = $clog2(SETTLE_CYC + 1);
  localparam int PA_W = $clog2(PAY_BYTES);

  typedef struct packed {
    rmps_mode_t st;
    logic [SC_W-1:0] cnt;
    rmps_pins_t pin1;
    rmps_pins_t pin2;
    rmps_pins_t pin3;
    rmps_cfg_t cfg1;
    rmps_cfg_t cfg;
    rmps_xing_t x1;
    rmps_xing_t x2;
    rmps_xing_t x3;
    logic req;
    logic rxen;
    logic osc;
    logic rpow;
    logic done;
    logic hit;
    logic src_tx;
    logic cs;
    logic [7:0] op;
    logic first;
    logic [2:0] bitn;
    logic [7:0] rsh;
    logic [7:0] tsh;
    logic [7:0] nxt;
    logic [5:0] idx;
    logic miso;
    logic [31:0] txa;
  } rmps_m_t;

  typedef struct packed {
    rmps_bst_t st;
    logic [8:0] cnt;
    logic [CRC_W-1:0] crc;
    logic [31:0] sh;
    logic [7:0] byt;
    logic r1;
    logic r2;
    logic e1;
    logic e2;
    rmps_xing_t x;
    logic ton;
    logic tmod;
    logic tdat;
  } rmps_b_t;

  rmps_m_t m_q, m_d;
  rmps_b_t b_q, b_d;
  logic [7:0] tx_buf [PAY_BYTES];
  logic [7:0] rx_buf [PAY_BYTES];
  logic tx_we, rx_we, rd_all;
  logic [7:0] rx_wd, by;
  logic brst1, brst2;

  function automatic logic [31:0] pack_addr(input logic [31:0] a, input logic [2:0] n);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < `RMPS_ADR_BYTES; k++) begin
      if (k < int'(n)) r = {r[23:0], a[8*k+:8]};
    end
    return r;
  endfunction : pack_addr

  function automatic logic [CRC_W-1:0] crc_bit(input logic [CRC_W-1:0] c, input logic b);
    logic [CRC_W-1:0] r;
    r = {c[CRC_W-2:0], 1'b0};
    if (c[CRC_W-1] ^ b) r = r ^ CRC_POLY;
    return r;
  endfunction : crc_bit

  function automatic logic [CRC_W-1:0] crc_vec(input logic [CRC_W-1:0] c,
      input logic [31:0] v, input logic [5:0] n);
    logic [CRC_W-1:0] r;
    r = c;
    for (int k = 31; k >= 0; k--) begin
      if (k < int'(n)) r = crc_bit(r, v[k]);
    end
    return r;
  endfunction : crc_vec

  function automatic logic [7:0] rx_rd(input logic [5:0] i);
    logic [7:0] r;
    r = 8'h00;
    if (m_q.done && int'(i) < PAY_BYTES) r = rx_buf[i[PA_W-1:0]];
    return r;
  endfunction : rx_rd

  // System clock domain: mode control, flags, SPI
  always_comb begin
    rmps_mode_t want;
    logic sck_r, sck_f, csn_f, clr_tx;
    logic [7:0] stat;
    want = M_OFF;
    sck_r = 1'b0;
    sck_f = 1'b0;
    csn_f = 1'b0;
    clr_tx = 1'b0;
    stat = 8'h00;
    m_d = m_q;
    tx_we = 1'b0;
    rd_all = 1'b0;
    m_d.pin1 = '{I_CHIP_POWER_REQUEST, I_RADIO_ENABLE_INPUT, I_TRANSMIT_SELECT,
                 I_SCK, I_CSN, I_MOSI, I_RF_CARRIER};
    m_d.pin2 = m_q.pin1;
    m_d.pin3 = m_q.pin2;
    m_d.cfg1 = '{I_REPEAT_SEND_BIT, I_TX_AFW, I_RX_AFW, I_TX_PW, I_RX_PW, I_RX_ADDR};
    m_d.x1 = b_q.x;
    m_d.x2 = m_q.x1;
    m_d.x3 = m_q.x2;
    by = {m_q.rsh[6:0], m_q.pin2.mosi};
    if (!m_q.pin2.pwr) begin
      want = M_OFF;
    end else if (!m_q.pin2.ce) begin
      want = M_STBY;
    end else if (m_q.pin2.txen) begin
      want = M_TX;
    end else begin
      want = M_RXS;
    end
    case (m_q.st)
      M_OFF, M_STBY: begin
        m_d.cfg = m_q.cfg1;
        m_d.st = want;
        m_d.cnt = '0;
        m_d.req = (want == M_TX);
      end
      M_RXS: begin
        if (want != M_RXS) begin
          m_d.st = want;
          m_d.req = (want == M_TX);
        end else if (m_q.cnt == SC_W'(SETTLE_CYC - 1)) begin
          m_d.st = M_RX;
          m_d.rxen = 1'b1;
        end else begin
          m_d.cnt = m_q.cnt + SC_W'(1);
        end
      end
      M_RX: begin
        if (want != M_RXS) begin
          m_d.rxen = 1'b0;
          m_d.st = want;
          m_d.cnt = '0;
          m_d.req = (want == M_TX);
        end
      end
      M_TX: begin
        if (want != M_TX) begin
          m_d.req = 1'b0;
          m_d.st = M_DRAIN;
        end
      end
      M_DRAIN: begin
        if (!m_q.x2.ack && !m_q.x2.busy) begin
          m_d.st = want;
          m_d.cnt = '0;
          m_d.req = (want == M_TX);
        end
      end
      default: m_d.st = M_OFF;
    endcase
    m_d.osc = (m_d.st != M_OFF);
    m_d.rpow = (m_d.st != M_OFF) && (m_d.st != M_STBY);
    m_d.cs = m_q.pin2.car && (m_q.st == M_RX);

    // SPI slave
    stat[`RMPS_ST_DONE] = m_q.done;
    stat[`RMPS_ST_HIT] = m_q.hit;
    sck_r = m_q.pin2.sck && !m_q.pin3.sck;
    sck_f = !m_q.pin2.sck && m_q.pin3.sck;
    csn_f = !m_q.pin2.csn && m_q.pin3.csn;
    if (m_q.pin2.csn) begin
      m_d.bitn = 3'h0;
      m_d.first = 1'b1;
      m_d.idx = 6'h00;
    end else if (csn_f) begin
      m_d.miso = stat[7];
      m_d.tsh = {stat[6:0], 1'b0};
    end else if (sck_r) begin
      m_d.rsh = by;
      m_d.bitn = m_q.bitn + 3'h1;
      if (m_q.bitn == 3'h7) begin
        if (m_q.first) begin
          m_d.first = 1'b0;
          m_d.op = by;
          m_d.nxt = (by == `RMPS_OP_R_RXPAY) ? rx_rd(6'h00) : 8'h00;
        end else begin
          m_d.idx = m_q.idx + 6'h01;
          m_d.nxt = 8'h00;
          if (m_q.op == `RMPS_OP_W_TXPAY && int'(m_q.idx) < PAY_BYTES) begin
            tx_we = 1'b1;
          end else if (m_q.op == `RMPS_OP_W_TXADR && int'(m_q.idx) < `RMPS_ADR_BYTES) begin
            m_d.txa[{m_q.idx[1:0], 3'b000}+:8] = by;
          end else if (m_q.op == `RMPS_OP_R_RXPAY) begin
            m_d.nxt = rx_rd(m_q.idx + 6'h01);
            rd_all = (m_q.idx + 6'h01 == m_q.cfg.rx_pw);
          end
        end
      end
    end else if (sck_f) begin
      if (m_q.bitn == 3'h0) begin
        m_d.miso = m_q.nxt[7];
        m_d.tsh = {m_q.nxt[6:0], 1'b0};
      end else begin
        m_d.miso = m_q.tsh[7];
        m_d.tsh = {m_q.tsh[6:0], 1'b0};
      end
    end

    // Flags: a set in the same cycle beats a clear
    clr_tx = m_q.src_tx && (!m_q.pin2.txen || !m_q.pin2.pwr);
    if (clr_tx || rd_all) m_d.done = 1'b0;
    if (rd_all) m_d.hit = 1'b0;
    if (m_q.x2.dt != m_q.x3.dt) begin
      m_d.done = 1'b1;
      m_d.src_tx = 1'b1;
    end
    if (m_q.x2.ot != m_q.x3.ot) begin
      m_d.done = 1'b1;
      m_d.src_tx = 1'b0;
    end
    if (m_q.x2.ht != m_q.x3.ht) m_d.hit = 1'b1;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      m_q <= '0;
      m_q.st <= M_OFF;
      m_q.pin1.csn <= 1'b1;
      m_q.pin2.csn <= 1'b1;
      m_q.pin3.csn <= 1'b1;
      m_q.cfg.tx_afw <= `RMPS_AFW_RST;
      m_q.cfg.rx_afw <= `RMPS_AFW_RST;
      m_q.cfg.tx_pw <= `RMPS_PW_RST;
      m_q.cfg.rx_pw <= `RMPS_PW_RST;
      m_q.cfg.rx_adr <= `RMPS_ADR_RST;
      m_q.first <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (tx_we) tx_buf[m_q.idx[PA_W-1:0]] <= by;
  end

  // Bit clock domain: framer
  always_ff @(posedge I_BIT_CLK) begin
    brst1 <= I_SYS_RST;
    brst2 <= brst1;
  end

  always_comb begin
    logic [31:0] tav, rav, nsh, amask;
    logic [8:0] nc, alt, plt, alr, plr;
    logic bv;
    b_d = b_q;
    rx_we = 1'b0;
    rx_wd = {b_q.byt[6:0], I_RF_RX_DATA};
    b_d.r1 = m_q.req;
    b_d.r2 = b_q.r1;
    b_d.e1 = m_q.rxen;
    b_d.e2 = b_q.e1;
    b_d.x.ack = b_q.r2;
    tav = pack_addr(m_q.txa, m_q.cfg.tx_afw);
    rav = pack_addr(m_q.cfg.rx_adr, m_q.cfg.rx_afw);
    alt = {3'b000, m_q.cfg.tx_afw, 3'b000};
    plt = {m_q.cfg.tx_pw, 3'b000};
    alr = {3'b000, m_q.cfg.rx_afw, 3'b000};
    plr = {m_q.cfg.rx_pw, 3'b000};
    amask = (32'h1 << alr[5:0]) - 32'h1;
    if (alr[5]) amask = 32'hffffffff;
    nsh = {b_q.sh[30:0], I_RF_RX_DATA};
    nc = b_q.cnt + 9'h001;
    bv = 1'b0;
    case (b_q.st)
      B_IDLE: begin
        if (b_q.r2) begin
          b_d.st = B_PRE;
          b_d.cnt = 9'h000;
          b_d.crc = CRC_INIT;
          b_d.x.busy = 1'b1;
        end else if (b_q.e2) begin
          b_d.st = B_HUNT;
          b_d.sh = 32'h0;
        end
      end
      B_PRE: begin
        bv = ~b_q.cnt[0];
        b_d.cnt = nc;
        if (nc == `RMPS_PRE_BITS) begin
          b_d.st = B_ADR;
          b_d.cnt = 9'h000;
        end
      end
      B_ADR: begin
        bv = tav[5'(alt - nc)];
        b_d.crc = crc_bit(b_q.crc, bv);
        b_d.cnt = nc;
        if (nc >= alt) begin
          b_d.st = B_PAY;
          b_d.cnt = 9'h000;
        end
      end
      B_PAY: begin
        bv = tx_buf[b_q.cnt[PA_W+2:3]][3'h7 - b_q.cnt[2:0]];
        b_d.crc = crc_bit(b_q.crc, bv);
        b_d.cnt = nc;
        if (nc >= plt) begin
          b_d.st = B_CRC;
          b_d.cnt = 9'h000;
        end
      end
      B_CRC: begin
        bv = b_q.crc[CRC_W-1];
        b_d.crc = {b_q.crc[CRC_W-2:0], 1'b0};
        b_d.cnt = nc;
        if (nc == 9'(CRC_W)) begin
          b_d.x.dt = ~b_q.x.dt;
          b_d.cnt = 9'h000;
          if (b_q.r2 && m_q.cfg.rep) begin
            b_d.st = B_PRE;
            b_d.crc = CRC_INIT;
          end else if (b_q.r2) begin
            b_d.st = B_CW;
            b_d.x.busy = 1'b0;
          end else begin
            b_d.st = B_IDLE;
            b_d.x.busy = 1'b0;
          end
        end
      end
      B_CW: begin
        if (!b_q.r2) begin
          b_d.st = B_IDLE;
        end
      end
      B_HUNT: begin
        b_d.sh = nsh;
        if (!b_q.e2) begin
          b_d.st = B_IDLE;
        end else if (alr != 9'h000 && ((nsh ^ rav) & amask) == 32'h0) begin
          b_d.x.ht = ~b_q.x.ht;
          b_d.crc = crc_vec(CRC_INIT, rav, alr[5:0]);
          b_d.st = B_RPAY;
          b_d.cnt = 9'h000;
        end
      end
      B_RPAY: begin
        b_d.byt = rx_wd;
        b_d.crc = crc_bit(b_q.crc, I_RF_RX_DATA);
        b_d.cnt = nc;
        rx_we = (b_q.cnt[2:0] == 3'h7);
        if (!b_q.e2) begin
          b_d.st = B_IDLE;
          rx_we = 1'b0;
        end else if (nc >= plr) begin
          b_d.st = B_RCRC;
          b_d.cnt = 9'h000;
        end
      end
      B_RCRC: begin
        b_d.crc = crc_bit(b_q.crc, I_RF_RX_DATA);
        b_d.cnt = nc;
        if (!b_q.e2) begin
          b_d.st = B_IDLE;
        end else if (nc == 9'(CRC_W)) begin
          b_d.st = B_IDLE;
          if (b_d.crc == '0) b_d.x.ot = ~b_q.x.ot;
        end
      end
      default: b_d.st = B_IDLE;
    endcase
    if (b_q.st == B_CW) bv = 1'b0;
    // Modulation and carrier framed with the bit they carry
    b_d.tdat = bv;
    b_d.tmod = (b_q.st == B_PRE) || (b_q.st == B_ADR) || (b_q.st == B_PAY)
      || (b_q.st == B_CRC);
    b_d.ton = b_d.tmod || (b_q.st == B_CW);
  end

  always_ff @(posedge I_BIT_CLK) begin
    if (brst2) begin
      b_q <= '0;
      b_q.st <= B_IDLE;
    end else begin
      b_q <= b_d;
    end
  end

  always_ff @(posedge I_BIT_CLK) begin
    if (rx_we) rx_buf[b_q.cnt[PA_W+2:3]] <= rx_wd;
  end

  assign O_MISO = m_q.miso;
  assign O_PACKET_DONE_FLAG = m_q.done;
  assign O_ADDRESS_HIT_FLAG = m_q.hit;
  assign O_CARRIER_SENSE_FLAG = m_q.cs;
  assign O_OSC_ON = m_q.osc;
  assign O_RADIO_POWER = m_q.rpow;
  assign O_RX_LISTEN = m_q.rxen;
  assign O_TX_CARRIER = b_q.ton;
  assign O_TX_MODULATE = b_q.tmod;
  assign O_TX_DATA = b_q.tdat;
endmodule : rmps_core
`default_nettype wire

// >>> verif/rmps_core_asserts.sv
// Purpose: Port checks of the radio mode packet sequencer
// Assumes: All watched ports sampled on I_CLK
// Notes: Bound into rmps_core below
`timescale 1ns/100ps
`default_nettype none
module rmps_core_asserts #(
  parameter int SETTLE_CYC = 13000
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CHIP_POWER_REQUEST,
  input wire logic I_RADIO_ENABLE_INPUT,
  input wire logic I_TRANSMIT_SELECT,
  input wire logic I_CSN,
  input wire logic I_RF_CARRIER,
  input wire logic O_MISO,
  input wire logic O_PACKET_DONE_FLAG,
  input wire logic O_ADDRESS_HIT_FLAG,
  input wire logic O_CARRIER_SENSE_FLAG,
  input wire logic O_OSC_ON,
  input wire logic O_RADIO_POWER,
  input wire logic O_RX_LISTEN
);
  int pw_cnt_q;
  // Cycles of radio power held high
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || !O_RADIO_POWER) pw_cnt_q <= 0;
    else pw_cnt_q <= pw_cnt_q + 1;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_off_quiet;
    !I_CHIP_POWER_REQUEST [*6] |-> !O_RX_LISTEN && !O_CARRIER_SENSE_FLAG;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("listening in power down");
  property p_stby_quiet;
    !I_RADIO_ENABLE_INPUT [*6] |-> !O_RX_LISTEN;
  endproperty
  a_stby_quiet: assert property (p_stby_quiet)
    else $error("listening with radio disabled");
  property p_listen_pwr;
    O_RX_LISTEN |-> O_RADIO_POWER && O_OSC_ON;
  endproperty
  a_listen_pwr: assert property (p_listen_pwr)
    else $error("listening without radio power");
  property p_settle;
    $rose(O_RX_LISTEN) |-> pw_cnt_q >= SETTLE_CYC - 2;
  endproperty
  a_settle: assert property (p_settle)
    else $error("listening before settle time");
  property p_cs_on;
    (O_RX_LISTEN && I_RF_CARRIER) [*5] |-> O_CARRIER_SENSE_FLAG;
  endproperty
  a_cs_on: assert property (p_cs_on)
    else $error("carrier not flagged");
  property p_cs_off;
    !I_RF_CARRIER [*5] |-> !O_CARRIER_SENSE_FLAG;
  endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("carrier flag without carrier");
  property p_status;
    $fell(I_CSN) |-> ##5 O_MISO == $past(O_PACKET_DONE_FLAG, 5);
  endproperty
  a_status: assert property (p_status)
    else $error("status bit wrong after select");
  property p_done_clr;
    $fell(O_PACKET_DONE_FLAG) |-> !$past(I_TRANSMIT_SELECT, 2)
      || !$past(I_CHIP_POWER_REQUEST, 2) || !$past(I_CSN, 2);
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("done flag cleared without cause");
  property p_hit_clr;
    $fell(O_ADDRESS_HIT_FLAG) |-> !$past(I_CSN, 2);
  endproperty
  a_hit_clr: assert property (p_hit_clr)
    else $error("hit flag cleared without read");
  c_done: cover property ($rose(O_PACKET_DONE_FLAG));
  c_hit: cover property ($rose(O_ADDRESS_HIT_FLAG));
  c_listen: cover property ($rose(O_RX_LISTEN));
endmodule : rmps_core_asserts
bind rmps_core rmps_core_asserts #(.SETTLE_CYC(SETTLE_CYC)) i_rmps_core_asserts (
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CHIP_POWER_REQUEST(I_CHIP_POWER_REQUEST),
  .I_RADIO_ENABLE_INPUT(I_RADIO_ENABLE_INPUT), .I_TRANSMIT_SELECT(I_TRANSMIT_SELECT),
  .I_CSN(I_CSN), .I_RF_CARRIER(I_RF_CARRIER), .O_MISO(O_MISO),
  .O_PACKET_DONE_FLAG(O_PACKET_DONE_FLAG), .O_ADDRESS_HIT_FLAG(O_ADDRESS_HIT_FLAG),
  .O_CARRIER_SENSE_FLAG(O_CARRIER_SENSE_FLAG), .O_OSC_ON(O_OSC_ON),
  .O_RADIO_POWER(O_RADIO_POWER), .O_RX_LISTEN(O_RX_LISTEN));
`default_nettype wire

// >>> verif/rmps_host.sv
// Purpose: Host side SPI master
// Assumes: SCK at I_CLK/8, changes on I_CLK falling edge
// Notes: Tasks called from the bench
`timescale 1ns/100ps
`default_nettype none
module rmps_host (
  input wire logic I_CLK,
  input wire logic I_MISO,
  output logic O_SCK,
  output logic O_CSN,
  output logic O_MOSI
);
  initial begin
    O_SCK = 0;
    O_CSN = 1;
    O_MOSI = 0;
  end
  // Mode 0, MSB first, sample at rising SCK
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      O_MOSI = tx[i];
      repeat (4) @(negedge I_CLK);
      O_SCK = 1;
      rx[i] = I_MISO;
      repeat (4) @(negedge I_CLK);
      O_SCK = 0;
    end
  endtask : xfer
  // Gap keeps select inactive time
  task automatic sel(input logic on);
    repeat (12) @(negedge I_CLK);
    O_CSN = ~on;
  endtask : sel
endmodule : rmps_host
`default_nettype wire

// >>> verif/rmps_tb.sv
// Purpose: Self-checking bench of the sequencer
// Assumes: Short settle count in simulation
// Notes: Host model drives SPI, bench drives radio side
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rmps_pkg::*;
  logic clk = 0, bclk = 0, rst = 1, pwr = 0, ce = 1, txen = 1, car = 0, rxd = 0;
  logic sck, csn, mosi, miso, done, hit, cs, osc, rpw, lst, tcar, tmod, tdat;
  logic [7:0] st;
  logic txq[$], rxq[$], exq[$];
  int errors = 0, n_checks = 0;
  // Long varied own address
  rmps_cfg_t cfg = '{rep: 0, tx_afw: 3, rx_afw: 3, tx_pw: 2, rx_pw: 2, rx_adr: 32'h00c53a96};
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #24 bclk = ~bclk;
  end
  always @(negedge bclk) begin
    if (rxq.size() > 0) rxd <= rxq.pop_front();
    else rxd <= ~rxd;
    if (tmod) txq.push_back(tdat);
  end
  rmps_core #(.SETTLE_CYC(20)) i_rmps_core (.I_CLK(clk), .I_SYS_RST(rst), .I_BIT_CLK(bclk),
    .I_CHIP_POWER_REQUEST(pwr), .I_RADIO_ENABLE_INPUT(ce), .I_TRANSMIT_SELECT(txen),
    .I_SCK(sck), .I_CSN(csn), .I_MOSI(mosi), .I_REPEAT_SEND_BIT(cfg.rep),
    .I_TX_AFW(cfg.tx_afw), .I_RX_AFW(cfg.rx_afw), .I_TX_PW(cfg.tx_pw), .I_RX_PW(cfg.rx_pw),
    .I_RX_ADDR(cfg.rx_adr), .I_RF_CARRIER(car), .I_RF_RX_DATA(rxd), .O_MISO(miso),
    .O_PACKET_DONE_FLAG(done), .O_ADDRESS_HIT_FLAG(hit), .O_CARRIER_SENSE_FLAG(cs),
    .O_OSC_ON(osc), .O_RADIO_POWER(rpw), .O_RX_LISTEN(lst), .O_TX_CARRIER(tcar),
    .O_TX_MODULATE(tmod), .O_TX_DATA(tdat));
  rmps_host i_rmps_host (.I_CLK(clk), .I_MISO(miso), .O_SCK(sck), .O_CSN(csn), .O_MOSI(mosi));
  task automatic chk(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h", $time, m, got);
    end
  endtask : chk8
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wait_for(ref logic s, input logic v, input int lim, input string m);
    for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
    chk(s, v, m);
  endtask : wait_for
  // Expected frame: preamble, bytes MSB first, CRC
  task automatic mk(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    exq = {};
    for (int i = 0; i < 10; i++) exq.push_back(~i[0]);
    foreach (b[k]) for (int j = 7; j >= 0; j--) begin
      exq.push_back(b[k][j]);
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k][j]) ? 16'h1021 : 16'h0000);
    end
    for (int j = 15; j >= 0; j--) exq.push_back(c[j]);
  endtask : mk
  task automatic spi(input logic [7:0] op, inout logic [7:0] d[$]);
    logic [7:0] r;
    i_rmps_host.sel(1);
    i_rmps_host.xfer(op, r);
    st = r;
    foreach (d[i]) begin
      i_rmps_host.xfer(d[i], r);
      d[i] = r;
    end
    i_rmps_host.sel(0);
  endtask : spi
  task automatic t_modes;
    cyc(8);
    chk(osc, 0, "off osc");
    pwr = 1;
    ce = 0;
    cyc(8);
    chk(osc, 1, "stby osc");
    chk(rpw, 0, "stby radio");
    txen = 0;
    ce = 1;
    cyc(8);
    chk(rpw, 1, "rx radio");
    chk(lst, 0, "settling");
    wait_for(lst, 1, 30, "listen");
    $display("t_modes done");
  endtask : t_modes
  task automatic t_rx;
    logic [7:0] d[$];
    car = 1;
    cyc(8);
    chk(cs, 1, "carrier");
    mk({8'h96, 8'h3a, 8'hc5, 8'h5e, 8'ha1});
    rxq = exq;
    for (int i = 0; i < 100 && rxq.size() > 32; i++) @(negedge clk);
    wait_for(hit, 1, 20, "hit");
    chk(done, 0, "early done");
    wait_for(done, 1, 100, "rx done");
    car = 0;
    cyc(8);
    chk(cs, 0, "no carrier");
    ce = 0;
    d = {8'h00, 8'h00};
    spi(8'h24, d);
    chk8(st, 8'ha0, "status");
    chk8(d[0], 8'h5e, "pay0");
    chk8(d[1], 8'ha1, "pay1");
    cyc(6);
    chk(done, 0, "done clr");
    chk(hit, 0, "hit clr");
    spi(8'h24, d);
    chk8(d[0], 8'h00, "stale pay");
    $display("t_rx done");
  endtask : t_rx
  task automatic t_tx;
    logic [7:0] d[$];
    d = {8'h96, 8'h3a, 8'hc5};
    spi(8'h22, d);
    d = {8'h3c, 8'hd2};
    spi(8'h20, d);
    mk({8'h96, 8'h3a, 8'hc5, 8'h3c, 8'hd2});
    txq = {};
    ce = 1;
    txen = 1;
    wait_for(tmod, 1, 20, "mod on");
    ce = 0;
    wait_for(done, 1, 200, "tx done");
    chk(txq.size() == 66, 1, "tx len");
    foreach (exq[i]) chk(txq[i], exq[i], "tx bit");
    cyc(8);
    chk(rpw, 0, "stby after tx");
    txen = 0;
    wait_for(done, 0, 8, "done clr");
    $display("t_tx done");
  endtask : t_tx
  task automatic t_cw;
    ce = 1;
    txen = 1;
    wait_for(done, 1, 250, "tx done");
    cyc(10);
    chk(tcar, 1, "carrier on");
    chk(tmod, 0, "unmodulated");
    txen = 0;
    wait_for(done, 0, 8, "done clr");
    wait_for(lst, 1, 40, "to rx");
    $display("t_cw done");
  endtask : t_cw
  task automatic t_rep;
    ce = 0;
    cyc(8);
    cfg.rep = 1;
    cyc(8);
    txq = {};
    ce = 1;
    txen = 1;
    cyc(200);
    chk(txq.size() > 66, 1, "resend");
    ce = 0;
    wait_for(rpw, 0, 150, "stby");
    chk(txq.size() % 66 == 0, 1, "whole packets");
    txen = 0;
    cfg.rep = 0;
    cyc(8);
    $display("t_rep done");
  endtask : t_rep
  task automatic t_abort;
    logic [7:0] d[$];
    ce = 1;
    wait_for(lst, 1, 40, "listen");
    rxq = exq;
    wait_for(hit, 1, 80, "hit");
    txen = 1;
    wait_for(lst, 0, 8, "rx dropped");
    wait_for(tmod, 1, 30, "to tx");
    wait_for(done, 1, 250, "tx done");
    txen = 0;
    ce = 0;
    wait_for(done, 0, 8, "done clr");
    d = {8'h00};
    spi(8'h24, d);
    chk8(d[0], 8'h00, "lost packet");
    $display("t_abort done");
  endtask : t_abort
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    t_modes();
    t_rx();
    t_tx();
    t_cw();
    t_rep();
    t_abort();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
